// *** bench/dcc_host_model.sv ***
// Host model driving the register port of the codec control bank
`timescale 1ns/1ns
module dcc_host_model (
  input  wire logic       i_clk,     // Core clock
  output logic            o_wr_en,   // Write strobe
  output logic            o_rd_en,   // Read strobe
  output logic      [7:0] o_addr,    // Register address
  output logic      [7:0] o_wr_data  // Write data
);
  initial
  begin
    o_wr_en   = 1'b0;
    o_rd_en   = 1'b0;
    o_addr    = 8'h00;
    o_wr_data = 8'h00;
  end

  // Idle address and data are inverted so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h06)
      return;
    @(negedge i_clk);
    o_wr_en   = 1'b1;
    o_addr    = a;
    o_wr_data = d;
    @(negedge i_clk);
    o_wr_en   = 1'b0;
    o_addr    = ~a;
    o_wr_data = ~d;
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge i_clk);
    o_rd_en = 1'b1;
    o_addr  = a;
    @(negedge i_clk);
    o_rd_en = 1'b0;
    o_addr  = ~a;
  endtask
endmodule

// *** bench/dcc_regs_test.sv ***
// Self-checking bench for the codec control register bank
`timescale 1ns/1ns
module dcc_regs_test;
  logic              i_clk = 1'b0;
  logic              i_arst_n = 1'b0;
  logic              wr_en;
  logic              rd_en;
  logic        [7:0] addr;
  logic        [7:0] wdata;
  logic        [7:0] rd_data;
  logic              rd_valid;
  logic              rd_hit;
  logic signed [5:0] steps;
  logic              mute;
  logic        [7:0] rsvd;
  wire         [7:0] route;
  wire         [7:0] ctl;
  logic        [8:0] exp_q[$];
  logic       [31:0] seed = 32'hd7e071a7;
  logic        [7:0] v;
  logic        [6:0] g;
  int                errors = 0;
  int                check_count = 0;

  always #20 i_clk = ~i_clk;

  dcc_host_model u_host (
    .i_clk     (i_clk),
    .o_wr_en   (wr_en),
    .o_rd_en   (rd_en),
    .o_addr    (addr),
    .o_wr_data (wdata)
  );

  dcc_regs u_dut (
    .i_clk                 (i_clk),
    .i_arst_n              (i_arst_n),
    .i_wr_en               (wr_en),
    .i_rd_en               (rd_en),
    .i_addr                (addr),
    .i_wr_data             (wdata),
    .o_rd_data             (rd_data),
    .o_rd_valid            (rd_valid),
    .o_rd_hit              (rd_hit),
    .o_dac1_gain_steps     (steps),
    .o_dac1_mute           (mute),
    .o_handset_input_en    (route[7]),
    .o_headset_input_en    (route[6]),
    .o_microphone_input_en (route[5]),
    .o_line_input_en       (route[4]),
    .o_caller_id_input_en  (route[3]),
    .o_handset_output_en   (route[2]),
    .o_headset_output_en   (route[1]),
    .o_speaker_output_en   (route[0]),
    .o_codec2_rsvd_div     (rsvd),
    .o_codec2_div_m1       (ctl[7:4]),
    .o_codec2_analog_loop  (ctl[3]),
    .o_codec2_digital_loop (ctl[2]),
    .o_codec2_power_down   (ctl[1]),
    .o_codec2_sw_reset     (ctl[0])
  );

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Returns {mute, steps}; undefined codes are taken as mute
  function logic [6:0] gain_exp(input logic [5:0] c);
    if (c == 6'h00)
      return 7'h00;
    if (c <= 6'h21)
      return {1'b0, c - 6'h19};
    return 7'h40;
  endfunction

  task automatic check(input string n, input logic [8:0] e, input logic [8:0] s);
    check_count++;
    if (s !== e)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({(a >= 8'h04 && a <= 8'h07), e});
    u_host.rd(a);
  endtask

  // Read answers stand one cycle, so they are taken at that falling edge
  always @(negedge i_clk)
  begin
    if (rd_valid === 1'b1)
      check("read", exp_q.pop_front(), {rd_hit, rd_data});
  end

  task automatic close_out();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #(40 * 20000);
    errors++;
    $display("[ERR] watchdog expected done seen hang");
    close_out();
  end

  initial
  begin
    repeat (6) @(negedge i_clk);
    i_arst_n = 1'b1;
    repeat (3) @(negedge i_clk);
    check("route", 9'h084, {1'b0, route});
    check("ctrl", 9'h050, {1'b0, ctl});
    check("gain", 9'h000, {2'b00, mute, steps});
    check("rsvd", 9'h050, {1'b0, rsvd});
    rd(8'h04, 8'h00);
    rd(8'h05, 8'h84);
    rd(8'h06, 8'h50);
    rd(8'h07, 8'h50);
    rd(8'h03, 8'h00);
    rd(8'h08, 8'h00);
    $display("test reset and decode done");
    u_host.wr(8'h08, 8'hff);
    u_host.wr(8'h03, 8'h00);
    check("route", 9'h084, {1'b0, route});
    check("ctrl", 9'h050, {1'b0, ctl});
    rd(8'hff, 8'h00);
    $display("test unmapped done");
    for (int i = 0; i < 12; i++)
    begin
      v = (i < 8) ? (8'h01 << i) : 8'(rnd());
      u_host.wr(8'h05, v);
      check("route", {1'b0, v}, {1'b0, route});
      rd(8'h05, v);
    end
    $display("test routing done");
    for (int c = 0; c < 64; c++)
    begin
      v = {2'(rnd()), c[5:0]};
      u_host.wr(8'h04, v);
      @(negedge i_clk);
      g = gain_exp(v[5:0]);
      check("gain", {2'b00, g}, {2'b00, mute, g[6] ? 6'h00 : steps});
      rd(8'h04, {2'b00, v[5:0]});
    end
    $display("test gain done");
    for (int i = 0; i < 10; i++)
    begin
      v = (i == 0) ? 8'hfe : (8'(rnd()) & 8'hfe);
      u_host.wr(8'h07, v);
      check("ctrl", {1'b0, v}, {1'b0, ctl});
      rd(8'h07, v);
    end
    $display("test codec2 control done");
    v = 8'(rnd());
    u_host.wr(8'h05, v);
    u_host.wr(8'h04, 8'h21);
    u_host.wr(8'h07, 8'hae);
    u_host.wr(8'h07, 8'hff);
    check("swreset", 9'h051, {1'b0, ctl});
    check("route", {1'b0, v}, {1'b0, route});
    check("rsvd", 9'h050, {1'b0, rsvd});
    @(negedge i_clk);
    check("ctrl", 9'h050, {1'b0, ctl});
    check("gain", 9'h008, {2'b00, mute, steps});
    rd(8'h07, 8'h50);
    rd(8'h05, v);
    $display("test software reset done");
    repeat (2) @(negedge i_clk);
    check("pending", 9'h000, 9'(exp_q.size()));
    close_out();
  end
endmodule

// *** src/dcc_gain_decode.sv ***
// Output amplifier gain code decoder, registered
`timescale 1ns/1ns
module dcc_gain_decode (
  input  wire logic       i_clk,        // Core clock
  input  wire logic       i_rst_n,      // Synchronised reset, active low
  input  wire logic [5:0] i_code,       // Gain code from register
  output logic signed [5:0] o_steps,    // Gain in 1.5 dB steps, two's complement
  output logic            o_mute        // Output path silenced
);

  logic signed [5:0] steps_d;
  logic signed [5:0] steps_q;
  logic              mute_d;
  logic              mute_q;

  always_comb
  begin
    steps_d = dcc_pkg::STEPS_ZERO;
    mute_d  = 1'b0;
    if (i_code == dcc_pkg::GAIN_MUTE_CODE)
    begin
      mute_d = 1'b1;
    end
    else if (i_code == dcc_pkg::GAIN_P12_CODE)
    begin
      steps_d = dcc_pkg::STEPS_P12;
    end
    else if (i_code == dcc_pkg::GAIN_P105_CODE)
    begin
      steps_d = dcc_pkg::STEPS_P105;
    end
    else if (i_code == dcc_pkg::GAIN_ZERO_CODE)
    begin
      steps_d = dcc_pkg::STEPS_ZERO;
    end
    else if (i_code <= dcc_pkg::GAIN_LIN_MAX)
    begin
      steps_d = i_code - dcc_pkg::GAIN_UNITY;
    end
    else
    begin
      // Undefined codes silence the path rather than guess a gain
      mute_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      steps_q <= dcc_pkg::STEPS_ZERO;
      mute_q  <= 1'b0;
    end
    else
    begin
      steps_q <= steps_d;
      mute_q  <= mute_d;
    end
  end

  assign o_steps = steps_q;
  assign o_mute  = mute_q;

  default clocking dcc_cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  mute_code_a: assert property (i_code == dcc_pkg::GAIN_MUTE_CODE |=> o_mute)
    else $error("mute code did not mute");
  top_gain_a: assert property (i_code == dcc_pkg::GAIN_P12_CODE |=> !o_mute && o_steps == 6'sh08)
    else $error("top gain code wrong");
  lin_gain_a: assert property ((i_code != 6'h00) && (i_code <= 6'h1f)
                               |=> !o_mute && o_steps == $signed($past(i_code) - 6'h19))
    else $error("linear gain step wrong");
  zero_unity_a: assert property ((i_code == 6'h00) || (i_code == 6'h19) |=> !o_mute && o_steps == 6'sh00)
    else $error("unity gain code wrong");

endmodule

// *** src/dcc_pkg.sv ***
// Constants for the codec control registers at addresses 4 to 7
package dcc_pkg;

  localparam logic [7:0] ADDR_C1_GAIN   = 8'h04;
  localparam logic [7:0] ADDR_C1_ROUTE  = 8'h05;
  localparam logic [7:0] ADDR_C2_RSVD   = 8'h06;
  localparam logic [7:0] ADDR_C2_CTRL   = 8'h07;

  localparam logic [5:0] GAIN_RST       = 6'h00;
  localparam logic [7:0] ROUTE_RST      = 8'h84;
  localparam logic [7:0] RSVD_RST       = 8'h50;
  localparam logic [7:0] CTRL_RST       = 8'h50;
  localparam logic [7:0] RD_ZERO        = 8'h00;

  // Routing register fields
  localparam int         RT_HS_IN       = 7;
  localparam int         RT_HD_IN       = 6;
  localparam int         RT_MC_IN       = 5;
  localparam int         RT_LN_IN       = 4;
  localparam int         RT_CI_IN       = 3;
  localparam int         RT_HS_OUT      = 2;
  localparam int         RT_HD_OUT      = 1;
  localparam int         RT_SP_OUT      = 0;

  // Codec 2 control fields
  localparam int         CT_DIV_HI      = 7;
  localparam int         CT_DIV_LO      = 4;
  localparam int         CT_ALOOP       = 3;
  localparam int         CT_DLOOP       = 2;
  localparam int         CT_PWRDN       = 1;
  localparam int         CT_SWRST       = 0;

  // Gain codes and step counts, one step is 1.5 dB
  localparam logic [5:0] GAIN_MUTE_CODE = 6'h30;
  localparam logic [5:0] GAIN_P12_CODE  = 6'h21;
  localparam logic [5:0] GAIN_P105_CODE = 6'h20;
  localparam logic [5:0] GAIN_ZERO_CODE = 6'h00;
  localparam logic [5:0] GAIN_LIN_MAX   = 6'h1f;
  localparam logic [5:0] GAIN_UNITY     = 6'h19;
  localparam logic [5:0] STEPS_P12      = 6'h08;
  localparam logic [5:0] STEPS_P105     = 6'h07;
  localparam logic [5:0] STEPS_ZERO     = 6'h00;

endpackage

// *** src/dcc_regs.sv ***
// Codec 1 gain/routing and codec 2 control register bank
`timescale 1ns/1ns
module dcc_regs (
  input  wire logic       i_clk,                // Core clock, 25 MHz
  input  wire logic       i_arst_n,             // Asynchronous reset, active low
  input  wire logic       i_wr_en,              // Write strobe from control port
  input  wire logic       i_rd_en,              // Read strobe from control port
  input  wire logic [7:0] i_addr,               // Register address
  input  wire logic [7:0] i_wr_data,            // Write data
  output logic      [7:0] o_rd_data,            // Read data, registered
  output logic            o_rd_valid,           // Read answer, one-cycle pulse
  output logic            o_rd_hit,             // Read address belongs here
  output logic signed [5:0] o_dac1_gain_steps,  // Codec 1 output gain, 1.5 dB steps
  output logic            o_dac1_mute,          // Codec 1 output muted
  output logic            o_handset_input_en,   // Handset input to codec 1
  output logic            o_headset_input_en,   // Headset input to codec 1
  output logic            o_microphone_input_en,// Microphone input to codec 1
  output logic            o_line_input_en,      // Line input to codec 1
  output logic            o_caller_id_input_en, // Caller id input to codec 1
  output logic            o_handset_output_en,  // Codec 1 to handset output
  output logic            o_headset_output_en,  // Codec 1 to headset output
  output logic            o_speaker_output_en,  // Codec 1 to speaker output
  output logic      [7:0] o_codec2_rsvd_div,    // Reserved divider settings
  output logic      [3:0] o_codec2_div_m1,      // Codec 2 divider, I minus one
  output logic            o_codec2_analog_loop, // Codec 2 analog loopback
  output logic            o_codec2_digital_loop,// Codec 2 digital loopback
  output logic            o_codec2_power_down,  // Codec 2 powered down
  output logic            o_codec2_sw_reset     // Pulse resetting codec 2 registers elsewhere
);

  logic [1:0] rst_sync_q;
  logic       rst_n;

  logic [5:0] gain_d;
  logic [5:0] gain_q;
  logic [7:0] route_d;
  logic [7:0] route_q;
  logic [7:0] rsvd_d;
  logic [7:0] rsvd_q;
  logic [7:0] ctrl_d;
  logic [7:0] ctrl_q;
  logic       swrst_d;
  logic       swrst_q;
  logic [7:0] rd_data_d;
  logic [7:0] rd_data_q;
  logic       rd_valid_d;
  logic       rd_valid_q;
  logic       rd_hit_d;
  logic       rd_hit_q;

  logic       wr_gain;
  logic       wr_route;
  logic       wr_rsvd;
  logic       wr_ctrl;

  // Reset asserts at once, releases through two flops
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rst_sync_q <= 2'h0;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  assign wr_gain  = i_wr_en && (i_addr == dcc_pkg::ADDR_C1_GAIN);
  assign wr_route = i_wr_en && (i_addr == dcc_pkg::ADDR_C1_ROUTE);
  assign wr_rsvd  = i_wr_en && (i_addr == dcc_pkg::ADDR_C2_RSVD);
  assign wr_ctrl  = i_wr_en && (i_addr == dcc_pkg::ADDR_C2_CTRL);

  always_comb
  begin
    gain_d  = gain_q;
    route_d = route_q;
    rsvd_d  = rsvd_q;
    ctrl_d  = ctrl_q;
    swrst_d = 1'b0;
    if (wr_gain)
    begin
      // Unused top bits are not stored
      gain_d = i_wr_data[5:0];
    end
    if (wr_route)
    begin
      route_d = i_wr_data;
    end
    if (wr_rsvd)
    begin
      // Stored as written; other values are the host's fault
      rsvd_d = i_wr_data;
    end
    if (wr_ctrl)
    begin
      if (i_wr_data[dcc_pkg::CT_SWRST])
      begin
        // Codec 2 only; codec 1 registers untouched
        rsvd_d  = dcc_pkg::RSVD_RST;
        ctrl_d  = dcc_pkg::CTRL_RST;
        swrst_d = 1'b1;
      end
      else
      begin
        ctrl_d = i_wr_data;
      end
    end
  end

  always_comb
  begin
    rd_data_d  = dcc_pkg::RD_ZERO;
    rd_valid_d = i_rd_en;
    rd_hit_d   = 1'b0;
    if (i_rd_en)
    begin
      rd_hit_d = 1'b1;
      case (i_addr)
        dcc_pkg::ADDR_C1_GAIN:  rd_data_d = {2'h0, gain_q};
        dcc_pkg::ADDR_C1_ROUTE: rd_data_d = route_q;
        dcc_pkg::ADDR_C2_RSVD:  rd_data_d = rsvd_q;
        dcc_pkg::ADDR_C2_CTRL:  rd_data_d = ctrl_q;
        default:                rd_hit_d  = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gain_q     <= dcc_pkg::GAIN_RST;
      route_q    <= dcc_pkg::ROUTE_RST;
      rsvd_q     <= dcc_pkg::RSVD_RST;
      ctrl_q     <= dcc_pkg::CTRL_RST;
      swrst_q    <= 1'b0;
      rd_data_q  <= dcc_pkg::RD_ZERO;
      rd_valid_q <= 1'b0;
      rd_hit_q   <= 1'b0;
    end
    else
    begin
      gain_q     <= gain_d;
      route_q    <= route_d;
      rsvd_q     <= rsvd_d;
      ctrl_q     <= ctrl_d;
      swrst_q    <= swrst_d;
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      rd_hit_q   <= rd_hit_d;
    end
  end

  // Decoded gain lags the register by one cycle; analog settling dwarfs it
  dcc_gain_decode u_gain (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_code  (gain_q),
    .o_steps (o_dac1_gain_steps),
    .o_mute  (o_dac1_mute)
  );

  assign o_rd_data             = rd_data_q;
  assign o_rd_valid            = rd_valid_q;
  assign o_rd_hit              = rd_hit_q;
  assign o_handset_input_en    = route_q[dcc_pkg::RT_HS_IN];
  assign o_headset_input_en    = route_q[dcc_pkg::RT_HD_IN];
  assign o_microphone_input_en = route_q[dcc_pkg::RT_MC_IN];
  assign o_line_input_en       = route_q[dcc_pkg::RT_LN_IN];
  assign o_caller_id_input_en  = route_q[dcc_pkg::RT_CI_IN];
  assign o_handset_output_en   = route_q[dcc_pkg::RT_HS_OUT];
  assign o_headset_output_en   = route_q[dcc_pkg::RT_HD_OUT];
  assign o_speaker_output_en   = route_q[dcc_pkg::RT_SP_OUT];
  assign o_codec2_rsvd_div     = rsvd_q;
  assign o_codec2_div_m1       = ctrl_q[dcc_pkg::CT_DIV_HI:dcc_pkg::CT_DIV_LO];
  assign o_codec2_analog_loop  = ctrl_q[dcc_pkg::CT_ALOOP];
  assign o_codec2_digital_loop = ctrl_q[dcc_pkg::CT_DLOOP];
  assign o_codec2_power_down   = ctrl_q[dcc_pkg::CT_PWRDN];
  assign o_codec2_sw_reset     = swrst_q;

  default clocking dcc_cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  sequence swrst_write_s;
    i_wr_en && i_addr == 8'h07 && i_wr_data[0];
  endsequence

  sequence ctrl_write_s;
    i_wr_en && i_addr == 8'h07 && !i_wr_data[0];
  endsequence

  // Pulse may legally stay high when a second reset write follows at once
  soft_reset_a: assert property (swrst_write_s |=> ctrl_q == 8'h50 && rsvd_q == 8'h50 && o_codec2_sw_reset
                                 ##1 (!o_codec2_sw_reset || $past(i_wr_en && i_addr == 8'h07 && i_wr_data[0])))
    else $error("software reset did not restore codec 2");
  codec1_kept_a: assert property (swrst_write_s |=> $stable(route_q) && $stable(gain_q))
    else $error("software reset touched codec 1");
  swrst_reads_zero_a: assert property (swrst_write_s ##[1:3] (i_rd_en && i_addr == 8'h07)
                                       |=> o_rd_data[0] == 1'b0)
    else $error("software reset bit read back set");
  ctrl_fields_a: assert property (ctrl_write_s |=> o_codec2_div_m1 == $past(i_wr_data[7:4])
                                  && o_codec2_analog_loop == $past(i_wr_data[3])
                                  && o_codec2_digital_loop == $past(i_wr_data[2])
                                  && o_codec2_power_down == $past(i_wr_data[1]))
    else $error("codec 2 control fields wrong");
  route_fields_a: assert property (i_wr_en && i_addr == 8'h05 |=>
                                   {o_handset_input_en, o_headset_input_en, o_microphone_input_en,
                                    o_line_input_en, o_caller_id_input_en, o_handset_output_en,
                                    o_headset_output_en, o_speaker_output_en} == $past(i_wr_data))
    else $error("routing enables wrong");
  reset_values_a: assert property ($rose(rst_n) |-> route_q == 8'h84 && ctrl_q == 8'h50 && gain_q == 6'h00)
    else $error("reset values wrong");
  read_route_a: assert property (i_rd_en && i_addr == 8'h05 |=> o_rd_valid && o_rd_hit
                                 && o_rd_data == $past(route_q))
    else $error("routing read wrong");
  unmapped_write_a: assert property (i_wr_en && (i_addr < 8'h04 || i_addr > 8'h07)
                                     |=> $stable(route_q) && $stable(ctrl_q) && $stable(gain_q))
    else $error("unmapped write changed a register");
  gain_mute_a: assert property (i_wr_en && i_addr == 8'h04 && i_wr_data[5:0] == 6'h30 |=> ##1 o_dac1_mute)
    else $error("mute write did not mute");

endmodule
